// [inc/stic_pkg.sv]
package stic_pkg;
  // apb register byte offsets
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_LEDLVL    = 8'h08;
  localparam logic [7:0]  ADDR_AUTOOFF   = 8'h0c;
  localparam logic [7:0]  ADDR_EVENT     = 8'h10;
  localparam logic [7:0]  ADDR_RXBYTE    = 8'h14;
  localparam logic [7:0]  ADDR_USBRPT    = 8'h18;
  // ctrl field positions and register reset values
  localparam int CTRL_INV      = 0;
  localparam int CTRL_TMODE_LO = 1;
  localparam int CTRL_TMODE_HI = 2;
  localparam int CTRL_USB      = 3;
  localparam int CTRL_CONC     = 4;
  localparam int CTRL_AUTOEN   = 5;
  localparam int CTRL_AIMEN    = 6;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0040;
  localparam logic [6:0]  LEDLVL_RESET = 7'h64;
  // event register bits (write-one actions from firmware)
  localparam int EV_DECODE  = 0;
  localparam int EV_TIMEOUT = 1;
  localparam int EV_SENT    = 2;
  localparam int EV_CHANGE  = 3;
  localparam int EV_STANDSYM= 4;
  localparam int EV_BEEP    = 5;
  // serial trigger bytes and usb report codes
  localparam logic [7:0] CH_SYN = 8'h16;
  localparam logic [7:0] CH_CR  = 8'h0d;
  localparam logic [7:0] CH_T_U = 8'h54;
  localparam logic [7:0] CH_T_L = 8'h74;
  localparam logic [7:0] CH_U_U = 8'h55;
  localparam logic [7:0] CH_U_L = 8'h75;
  localparam logic [7:0] USB_ACT   = 8'h04;
  localparam logic [7:0] USB_DEACT = 8'h00;
  // timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int PWM_PERIOD_NS = 100_000;
  localparam int PWM_CYC       = PWM_PERIOD_NS / (1_000_000_000 / CLK_HZ);
  localparam int GOOD_MS       = 50;
  localparam int GOOD_CYC      = GOOD_MS * (CLK_HZ / 1000);
  localparam int BEEP_MS       = 100;
  localparam int BEEP_CYC      = BEEP_MS * (CLK_HZ / 1000);
  localparam int FRAME_CYC     = 400;
  localparam int EXPO_CYC      = 250;
  localparam int AIM_CYC       = FRAME_CYC / 4;

  typedef enum logic [1:0] {
    TM_MANUAL = 2'h0,
    TM_LOWPWR = 2'h1,
    TM_PRES   = 2'h2,
    TM_STAND  = 2'h3
  } stic_tmode_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SCAN  = 6'h02,
    ST_SEND  = 6'h04,
    ST_WAITR = 6'h08,
    ST_OFF   = 6'h10,
    ST_STAND = 6'h20
  } stic_state_t;

  typedef enum logic [3:0] {
    RX_HUNT = 4'h1,
    RX_SYN  = 4'h2,
    RX_ACT  = 4'h4,
    RX_DEA  = 4'h8
  } stic_rx_t;

  typedef struct packed {
    logic illum;
    logic aim;
  } stic_leds_t;
endpackage : stic_pkg

// [rtl/stic_core.sv]
// Overview of operation
// - default serial polarity is normal, as seen by an rs-232 input
// - inverted polarity flips tx, rx, cts and rts logic sense
// - polarity select pin held low selects inverted polarity
// - manual mode idles until serial, usb or trigger pin activation
// - serial 16 T/t 0d activates, 16 U/u 0d deactivates trigger
// - usb report 04 activates, 00 deactivates trigger
// - optional auto deactivation after programmed time since activation
// - low-power manual mode only honoured with ttl serial interface
// - low-power mode removes scan power between scans, restored by trigger
// - no stop mode while wake request input is low
// - scan, indicate, send, power off only once trigger released
// - presentation mode lights leds only after field change
// - scan stand idles on stand symbol, scans otherwise
// - success indicator lights on good read
// - sounder driven with one fixed pwm tone on good read or beep event
// - led level 100..30 step 10 drives current, 0 turns off
// - interlaced: illumination during exposure, aimer in last quarter frame
// - aimer duty held near 25 percent in both modes
// - concurrent: illumination steady, aimer off during exposure
// - concurrent mode lowers illumination current
// - imaging timing runs from 12 or 24 mhz core clock
// - polarity pin low overrides configured polarity
// - powered-off flag high while in power-off mode
// - success active low; sounder idles high, driven low
// - wake request low wakes device from power off
//
// The register offsets and the APB slave port were chosen for this implementation.
module stic_core
  import stic_pkg::*;
#(
  parameter int CORE_MHZ = 24,
  parameter int AUTO_W   = 24
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        POLARITY_SELECT_IN,
  input  wire logic        TRIGGER_PIN_LOW,
  input  wire logic        WAKE_REQUEST,
  input  wire logic        RXD_PIN,
  input  wire logic        CTS_PIN,
  input  wire logic        TXD_CORE,
  input  wire logic        RTS_CORE,
  output logic             TXD_PIN,
  output logic             RTS_PIN,
  output logic             RXD_CORE,
  output logic             CTS_CORE,
  output logic             SCAN_POWER,
  output logic             TRIGGER_ACTIVE,
  output logic             POWERED_OFF_FLAG,
  output logic             SUCCESS_INDICATOR,
  output logic             SOUNDER_DRIVE,
  output logic             ILLUM_EN,
  output logic             AIMER_EN,
  output logic             EXPOSING,
  output logic      [6:0]  LED_CURRENT_LEVEL
);
  if (CORE_MHZ != 12 && CORE_MHZ != 24) begin : g_bad_core_clk
    $error("core clock must be 12 or 24 mhz");
  end
  if (AUTO_W < 1 || AUTO_W > 32) begin : g_bad_auto_w
    $error("auto width out of range");
  end
  // frame and tone counters are only 16 bits wide
  if (FRAME_CYC > 32'h0000_ffff || PWM_CYC > 32'h0000_ffff) begin : g_bad_counts
    $error("frame or tone period too long for its counter");
  end

  function automatic logic lvl_ok(input logic [6:0] v);
    lvl_ok = (v == 7'h00) || ((v >= 7'h1e) && (v <= 7'h64) && (v % 7'h0a == 7'h00));
  endfunction : lvl_ok

  // three-stage input sync, change accepted when stages two and three agree
  logic [2:0] trg_sy_ff, wak_sy_ff, inv_sy_ff;
  logic       trg_ff, wak_ff, inv_ff;
  logic       nxt_trg, nxt_wak, nxt_inv;
  always_comb begin
    nxt_trg = (trg_sy_ff[1] == trg_sy_ff[2]) ? trg_sy_ff[2] : trg_ff;
    nxt_wak = (wak_sy_ff[1] == wak_sy_ff[2]) ? wak_sy_ff[2] : wak_ff;
    nxt_inv = (inv_sy_ff[1] == inv_sy_ff[2]) ? inv_sy_ff[2] : inv_ff;
  end
  // reset to the released level, so no false edge follows reset
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      trg_sy_ff <= 3'h7;
      wak_sy_ff <= 3'h7;
      inv_sy_ff <= 3'h7;
      trg_ff    <= 1'b1;
      wak_ff    <= 1'b1;
      inv_ff    <= 1'b1;
    end else begin
      trg_sy_ff <= {trg_sy_ff[1:0], TRIGGER_PIN_LOW};
      wak_sy_ff <= {wak_sy_ff[1:0], WAKE_REQUEST};
      inv_sy_ff <= {inv_sy_ff[1:0], POLARITY_SELECT_IN};
      trg_ff    <= nxt_trg;
      wak_ff    <= nxt_wak;
      inv_ff    <= nxt_inv;
    end
  end

  // apb registers
  logic [31:0]       ctrl_ff, nxt_ctrl;
  logic [6:0]        lvl_ff, nxt_lvl;
  logic [AUTO_W-1:0] auto_ff, nxt_auto;
  logic [7:0]        rxb_ff, nxt_rxb;
  logic [7:0]        usb_ff, nxt_usb;
  logic              rxv_ff, nxt_rxv, usbv_ff, nxt_usbv;
  logic [5:0]        ev_ff, nxt_ev;
  logic              wr, rd_ok;
  assign wr      = PSEL && PENABLE && PWRITE;
  // zero wait states: every access ends in its first access cycle
  assign PREADY  = 1'b1;
  always_comb begin
    rd_ok = 1'b1;
    case (PADDR)
      ADDR_CTRL, ADDR_STATUS, ADDR_LEDLVL, ADDR_AUTOOFF,
      ADDR_EVENT, ADDR_RXBYTE, ADDR_USBRPT: rd_ok = 1'b1;
      default: rd_ok = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !rd_ok;

  stic_state_t st_ff, nxt_st;
  stic_rx_t    rx_ff, nxt_rx;
  logic        trig_ff, nxt_trig;
  logic [AUTO_W-1:0] acnt_ff, nxt_acnt;
  logic [31:0] good_ff, nxt_good, beep_ff, nxt_beep;
  logic [15:0] pwm_ff, nxt_pwm, frm_ff, nxt_frm;
  logic [31:0] status;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_lvl  = lvl_ff;
    nxt_auto = auto_ff;
    nxt_rxb  = rxb_ff;
    nxt_usb  = usb_ff;
    nxt_rxv  = 1'b0;
    nxt_usbv = 1'b0;
    // event bits live one cycle, so no set and clear can collide
    nxt_ev   = 6'h00;
    if (wr) begin
      case (PADDR)
        ADDR_CTRL:    nxt_ctrl = {25'h0, PWDATA[6:0]};
        // refused levels keep the old setting
        ADDR_LEDLVL:  if (lvl_ok(PWDATA[6:0])) nxt_lvl = PWDATA[6:0];
        ADDR_AUTOOFF: nxt_auto = PWDATA[AUTO_W-1:0];
        ADDR_EVENT:   nxt_ev = PWDATA[5:0];
        ADDR_RXBYTE: begin
          nxt_rxb = PWDATA[7:0];
          nxt_rxv = 1'b1;
        end
        ADDR_USBRPT: begin
          nxt_usb  = PWDATA[7:0];
          nxt_usbv = 1'b1;
        end
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  // serial trigger command parser
  logic ser_act, ser_deact;
  always_comb begin
    nxt_rx    = rx_ff;
    ser_act   = 1'b0;
    ser_deact = 1'b0;
    if (rxv_ff) begin
      case (rx_ff)
        RX_SYN:  nxt_rx = (rxb_ff == CH_T_U || rxb_ff == CH_T_L) ? RX_ACT :
                          (rxb_ff == CH_U_U || rxb_ff == CH_U_L) ? RX_DEA :
                          (rxb_ff == CH_SYN) ? RX_SYN : RX_HUNT;
        RX_ACT: begin
          ser_act = (rxb_ff == CH_CR);
          nxt_rx  = (rxb_ff == CH_SYN) ? RX_SYN : RX_HUNT;
        end
        RX_DEA: begin
          ser_deact = (rxb_ff == CH_CR);
          nxt_rx    = (rxb_ff == CH_SYN) ? RX_SYN : RX_HUNT;
        end
        default: nxt_rx = (rxb_ff == CH_SYN) ? RX_SYN : RX_HUNT;
      endcase
    end
  end

  logic usb_sel, lowpwr, usb_act, usb_deact, pin_act, pin_rel, act, deact, auto_hit;
  stic_tmode_t tmode;
  assign usb_sel   = ctrl_ff[CTRL_USB];
  assign tmode     = stic_tmode_t'(ctrl_ff[CTRL_TMODE_HI:CTRL_TMODE_LO]);
  assign lowpwr    = (tmode == TM_LOWPWR) && !usb_sel;
  assign usb_act   = usbv_ff && usb_sel && (usb_ff == USB_ACT);
  assign usb_deact = usbv_ff && usb_sel && (usb_ff == USB_DEACT);
  assign pin_act   = !trg_ff;
  // a released pin ends the trigger it raised, so low-power mode can power off
  assign pin_rel   = !trg_ff && nxt_trg;
  // a zero period disables auto release
  assign auto_hit  = ctrl_ff[CTRL_AUTOEN] && trig_ff && (auto_ff != '0) && (acnt_ff >= auto_ff);
  assign act       = ser_act || usb_act || pin_act;
  assign deact     = ser_deact || usb_deact || auto_hit || pin_rel;

  always_comb begin
    nxt_trig = trig_ff;
    nxt_acnt = acnt_ff;
    if (act && !trig_ff) begin
      nxt_trig = 1'b1;
      nxt_acnt = '0;
    end else if (deact) begin
      nxt_trig = 1'b0;
    end else if (trig_ff) begin
      nxt_acnt = acnt_ff + 1'b1;
    end
    // decode ends a host trigger; a held pin keeps scanning
    if (ev_ff[EV_DECODE] && !pin_act) nxt_trig = 1'b0;
  end

  // scan sequencing
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (tmode == TM_STAND) nxt_st = ST_STAND;
        else if (tmode == TM_PRES) begin
          if (ev_ff[EV_CHANGE]) nxt_st = ST_SCAN;
        end else if (trig_ff) nxt_st = ST_SCAN;
        else if (lowpwr && wak_ff && trg_ff) nxt_st = ST_OFF;
      end
      ST_SCAN:
        if (ev_ff[EV_DECODE] || ev_ff[EV_TIMEOUT]) nxt_st = ST_SEND;
        else if (!trig_ff && tmode != TM_PRES && tmode != TM_STAND) nxt_st = ST_IDLE;
      ST_SEND:
        if (ev_ff[EV_SENT]) nxt_st = lowpwr ? ST_WAITR : ST_IDLE;
      ST_WAITR:
        if (trg_ff && !trig_ff && wak_ff) nxt_st = ST_OFF;
        // pin still held: scan again rather than power off
        else if (trig_ff) nxt_st = ST_SCAN;
      ST_OFF:
        if (!trg_ff || !wak_ff) nxt_st = ST_IDLE;
      ST_STAND:
        if (tmode != TM_STAND) nxt_st = ST_IDLE;
        else if (ev_ff[EV_CHANGE] && !ev_ff[EV_STANDSYM]) nxt_st = ST_SCAN;
      default: nxt_st = ST_IDLE;
    endcase
  end

  // indicators
  logic in_scan;
  assign in_scan = (st_ff == ST_SCAN);
  always_comb begin
    nxt_good = (good_ff != 0) ? good_ff - 32'h1 : 32'h0;
    nxt_beep = (beep_ff != 0) ? beep_ff - 32'h1 : 32'h0;
    if (in_scan && ev_ff[EV_DECODE]) nxt_good = 32'(GOOD_CYC);
    if ((in_scan && ev_ff[EV_DECODE]) || ev_ff[EV_BEEP]) nxt_beep = 32'(BEEP_CYC);
    // one fixed tone; patterns are built from firmware beep events
    nxt_pwm = (pwm_ff >= 16'(PWM_CYC - 1)) ? 16'h0 : pwm_ff + 16'h1;
    nxt_frm = (frm_ff >= 16'(FRAME_CYC - 1)) ? 16'h0 : frm_ff + 16'h1;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_ff <= CTRL_RESET;
      lvl_ff  <= LEDLVL_RESET;
      auto_ff <= '0;
      rxb_ff  <= 8'h00;
      usb_ff  <= 8'h00;
      rxv_ff  <= 1'b0;
      usbv_ff <= 1'b0;
      ev_ff   <= 6'h00;
      rx_ff   <= RX_HUNT;
      trig_ff <= 1'b0;
      acnt_ff <= '0;
      st_ff   <= ST_IDLE;
      good_ff <= 32'h0;
      beep_ff <= 32'h0;
      pwm_ff  <= 16'h0;
      frm_ff  <= 16'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      lvl_ff  <= nxt_lvl;
      auto_ff <= nxt_auto;
      rxb_ff  <= nxt_rxb;
      usb_ff  <= nxt_usb;
      rxv_ff  <= nxt_rxv;
      usbv_ff <= nxt_usbv;
      ev_ff   <= nxt_ev;
      rx_ff   <= nxt_rx;
      trig_ff <= nxt_trig;
      acnt_ff <= nxt_acnt;
      st_ff   <= nxt_st;
      good_ff <= nxt_good;
      beep_ff <= nxt_beep;
      pwm_ff  <= nxt_pwm;
      frm_ff  <= nxt_frm;
    end
  end

  // outputs: registered
  logic       inv;
  stic_leds_t leds;
  logic       expo, scanning;
  assign inv      = ctrl_ff[CTRL_INV] || !inv_ff;
  assign scanning = in_scan && (lvl_ff != 7'h00);
  assign expo     = in_scan && (frm_ff < 16'(EXPO_CYC));
  always_comb begin
    leds.illum = 1'b0;
    leds.aim   = 1'b0;
    if (in_scan) begin
      // aim window fixed to a quarter frame so long exposures never stretch it
      leds.aim = ctrl_ff[CTRL_AIMEN] && (frm_ff >= 16'(FRAME_CYC - AIM_CYC));
      if (ctrl_ff[CTRL_CONC]) leds.illum = scanning;
      else leds.illum = scanning && expo;
    end
  end

  logic [6:0] drive_lvl;
  // concurrent halves current to cap peak supply draw
  assign drive_lvl = ctrl_ff[CTRL_CONC] ? (lvl_ff >> 1) : lvl_ff;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      TXD_PIN           <= 1'b1;
      RTS_PIN           <= 1'b1;
      RXD_CORE          <= 1'b1;
      CTS_CORE          <= 1'b1;
      SCAN_POWER        <= 1'b1;
      TRIGGER_ACTIVE    <= 1'b0;
      POWERED_OFF_FLAG  <= 1'b0;
      SUCCESS_INDICATOR <= 1'b1;
      SOUNDER_DRIVE     <= 1'b1;
      ILLUM_EN          <= 1'b0;
      AIMER_EN          <= 1'b0;
      EXPOSING          <= 1'b0;
      LED_CURRENT_LEVEL <= 7'h00;
    end else begin
      TXD_PIN           <= TXD_CORE ^ inv;
      RTS_PIN           <= RTS_CORE ^ inv;
      RXD_CORE          <= RXD_PIN ^ inv;
      CTS_CORE          <= CTS_PIN ^ inv;
      SCAN_POWER        <= (st_ff != ST_OFF);
      TRIGGER_ACTIVE    <= trig_ff;
      POWERED_OFF_FLAG  <= (st_ff == ST_OFF);
      SUCCESS_INDICATOR <= (good_ff == 0);
      SOUNDER_DRIVE     <= !((beep_ff != 0) && (pwm_ff < 16'(PWM_CYC / 2)));
      ILLUM_EN          <= leds.illum;
      AIMER_EN          <= leds.aim;
      EXPOSING          <= expo;
      LED_CURRENT_LEVEL <= leds.illum ? drive_lvl : 7'h00;
    end
  end

  // state one-hot at bits 13:8, pin levels shown active high
  assign status = {16'h0, 2'h0, st_ff, 3'h0, inv, !wak_ff, !trg_ff, trig_ff, POWERED_OFF_FLAG};
  always_comb begin
    PRDATA = 32'h0;
    if (PSEL && !PWRITE) begin
      case (PADDR)
        ADDR_CTRL:    PRDATA = ctrl_ff;
        ADDR_STATUS:  PRDATA = status;
        ADDR_LEDLVL:  PRDATA = {25'h0, lvl_ff};
        ADDR_AUTOOFF: PRDATA = 32'(auto_ff);
        ADDR_RXBYTE:  PRDATA = {24'h0, rxb_ff};
        ADDR_USBRPT:  PRDATA = {24'h0, usb_ff};
        default:      PRDATA = 32'h0;
      endcase
    end
  end
endmodule : stic_core

// [tb/stic_host.sv]
module stic_host (
  input  wire logic sys_clk,
  input  wire logic txd_pin,
  input  wire logic rts_pin,
  output logic      trigger_pin_low,
  output logic      wake_request,
  output logic      polarity_select_in,
  output logic      rxd_pin,
  output logic      cts_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic trig_hold = 1'b0;
  logic wake_hold = 1'b0;
  logic inv_tie   = 1'b0;
  logic rxd_ff    = 1'b1;

  // released lines are driven high, standing in for the pull-up level
  assign trigger_pin_low    = !trig_hold;
  assign wake_request       = !wake_hold;
  assign polarity_select_in = !inv_tie;
  assign rxd_pin            = rxd_ff;
  assign cts_pin            = rts_pin;

  // receive line toggles while txd_pin is low and holds while it is high
  always @(posedge sys_clk) rxd_ff <= ~rxd_ff ^ txd_pin;

  task set_pins(input logic trig, input logic wake, input logic inv);
    @(posedge sys_clk);
    trig_hold <= trig;
    wake_hold <= wake;
    inv_tie   <= inv;
  endtask : set_pins
endmodule : stic_host

// [tb/stic_monitor.sv]
module stic_monitor
  import stic_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RESETN,
  input wire logic       POLARITY_SELECT_IN,
  input wire logic       TRIGGER_PIN_LOW,
  input wire logic       WAKE_REQUEST,
  input wire logic       RXD_PIN,
  input wire logic       TXD_CORE,
  input wire logic       TXD_PIN,
  input wire logic       RXD_CORE,
  input wire logic       TRIGGER_ACTIVE,
  input wire logic       SCAN_POWER,
  input wire logic       POWERED_OFF_FLAG,
  input wire logic       ILLUM_EN,
  input wire logic       AIMER_EN,
  input wire logic       EXPOSING,
  input wire logic [6:0] LED_CURRENT_LEVEL
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] pol_cnt_ff;
  logic [2:0] nxt_pol_cnt;
  logic [7:0] aim_cnt_ff;
  logic [7:0] nxt_aim_cnt;

  // saturating run lengths, so a stuck level cannot wrap back into range
  always_comb begin
    nxt_pol_cnt = POLARITY_SELECT_IN ? 3'h0 : pol_cnt_ff + 3'(pol_cnt_ff != 3'h7);
    nxt_aim_cnt = AIMER_EN ? aim_cnt_ff + 8'(aim_cnt_ff != 8'hff) : 8'h00;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pol_cnt_ff <= 3'h0;
      aim_cnt_ff <= 8'h00;
    end else begin
      pol_cnt_ff <= nxt_pol_cnt;
      aim_cnt_ff <= nxt_aim_cnt;
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  AST_OFF_NO_SCAN: assert property (POWERED_OFF_FLAG == !SCAN_POWER)
    else $error("scan power on while off");
  AST_TX_INV: assert property (pol_cnt_ff == 3'h7 |-> TXD_PIN == !$past(TXD_CORE))
    else $error("tx not inverted by pin");
  AST_RX_INV: assert property (pol_cnt_ff == 3'h7 |-> RXD_CORE == !$past(RXD_PIN))
    else $error("rx not inverted by pin");
  AST_AIM_EXPO: assert property (AIMER_EN |-> !EXPOSING)
    else $error("aimer on during exposure");
  AST_AIM_DUTY: assert property (aim_cnt_ff <= 8'(AIM_CYC))
    else $error("aimer burst too long");
  AST_LED_DARK: assert property (!ILLUM_EN |-> LED_CURRENT_LEVEL == 7'h00)
    else $error("led current without illumination");
  AST_WAKE_EXIT: assert property (POWERED_OFF_FLAG && !WAKE_REQUEST |-> ##[1:6] !POWERED_OFF_FLAG)
    else $error("wake did not end power off");
  AST_WAKE_HOLD: assert property (!WAKE_REQUEST [*5] |=> !$rose(POWERED_OFF_FLAG))
    else $error("power off with wake low");
  AST_TRIG_HOLD: assert property (!TRIGGER_PIN_LOW [*5] |=> !$rose(POWERED_OFF_FLAG))
    else $error("power off with trigger held");
  AST_TRIG_PIN: assert property (!TRIGGER_PIN_LOW [*8] |-> ##[0:8] TRIGGER_ACTIVE)
    else $error("trigger pin ignored");
  AST_TRIG_SYNC: assert property ($fell(TRIGGER_PIN_LOW) && !TRIGGER_ACTIVE |=> !TRIGGER_ACTIVE)
    else $error("trigger pin used unsynchronised");
endmodule : stic_monitor

// [tb/tb.sv]
module tb
  import stic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk, resetn, psel, penable, pwrite, txd_core, rts_core;
  logic [7:0]  paddr, rnd;
  logic [31:0] pwdata, prdata, rd_data;
  logic        pready, pslverr, slv_err, pol, trig_n, wake, rxd, cts, txd, rts;
  logic        scan_pwr, trig, off, good_n, snd, illum, aim, expo, cts_core;
  logic [6:0]  led_cur, lvl;
  logic [7:0]  tc [4] = '{CH_T_U, CH_U_U, CH_T_L, CH_U_L};
  int          fails, n_tests, i, k;

  stic_core dut (
    .SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .POLARITY_SELECT_IN(pol), .TRIGGER_PIN_LOW(trig_n), .WAKE_REQUEST(wake), .RXD_PIN(rxd),
    .CTS_PIN(cts), .TXD_CORE(txd_core), .RTS_CORE(rts_core), .TXD_PIN(txd), .RTS_PIN(rts),
    .RXD_CORE(), .CTS_CORE(cts_core), .SCAN_POWER(scan_pwr), .TRIGGER_ACTIVE(trig),
    .POWERED_OFF_FLAG(off), .SUCCESS_INDICATOR(good_n), .SOUNDER_DRIVE(snd),
    .ILLUM_EN(illum), .AIMER_EN(aim), .EXPOSING(expo), .LED_CURRENT_LEVEL(led_cur)
  );

  stic_host host (
    .sys_clk(sys_clk), .txd_pin(txd), .rts_pin(rts), .trigger_pin_low(trig_n),
    .wake_request(wake), .polarity_select_in(pol), .rxd_pin(rxd), .cts_pin(cts)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic exp_trig(input logic [7:0] c);
    return c == CH_T_U || c == CH_T_L;
  endfunction : exp_trig

  function automatic logic [6:0] exp_cur(input logic [6:0] l, input logic conc);
    return conc ? l >> 1 : l;
  endfunction : exp_cur

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : clk

  // request held until pready is seen at an edge; data taken at that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_data = prdata;
    slv_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task ser(input logic [7:0] c);
    wr(ADDR_RXBYTE, {24'h0, CH_SYN});
    wr(ADDR_RXBYTE, {24'h0, c});
    wr(ADDR_RXBYTE, {24'h0, CH_CR});
    clk(3);
  endtask : ser

  task wait_illum;
    for (k = 0; k < 2 * FRAME_CYC && illum !== 1'b1; k++)
      clk(1);
  endtask : wait_illum

  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end

  initial begin
    {resetn, psel, penable, pwrite, txd_core, rts_core} = '0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    rnd    = 8'h13;
    clk(3);
    chk("sounder idle", snd, 1'b1);
    chk("success idle", good_n, 1'b1);
    chk("off flag", off, 1'b0);
    resetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd_data, CTRL_RESET);
    apb(1'b0, ADDR_LEDLVL, 32'h0);
    chk("led reset", rd_data, {25'h0, LEDLVL_RESET});
    for (i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, CTRL_RESET | 32'(i == 1));
      host.set_pins(1'b0, 1'b0, i == 2);
      clk(6);
      repeat (4) begin
        rnd = lfsr(rnd);
        txd_core <= rnd[0];
        rts_core <= rnd[1];
        clk(3);
        chk("txd", txd, rnd[0] ^ (i != 0));
        chk("rts", rts, rnd[1] ^ (i != 0));
        chk("cts", cts_core, rnd[1]);
      end
    end
    host.set_pins(1'b0, 1'b0, 1'b0);
    wr(ADDR_CTRL, CTRL_RESET);
    for (i = 0; i < 4; i++) begin
      ser(tc[i]);
      chk("serial trigger", trig, exp_trig(tc[i]));
    end
    wr(ADDR_RXBYTE, {24'h0, CH_SYN});
    wr(ADDR_RXBYTE, {24'h0, CH_T_U});
    wr(ADDR_RXBYTE, 32'h0e);
    clk(3);
    chk("bad frame", trig, 1'b0);
    wr(ADDR_CTRL, 32'h48);
    for (i = 0; i < 2; i++) begin
      wr(ADDR_USBRPT, {24'h0, i ? USB_DEACT : USB_ACT});
      clk(3);
      chk("usb trigger", trig, i == 0);
    end
    rnd = lfsr(rnd);
    lvl = 7'h1e + 7'h0a * rnd[2:0];
    wr(ADDR_LEDLVL, {25'h0, lvl});
    wr(ADDR_LEDLVL, 32'h37);
    apb(1'b0, ADDR_LEDLVL, 32'h0);
    chk("led level", rd_data, {25'h0, lvl});
    for (i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, CTRL_RESET | (i << CTRL_CONC));
      ser(CH_T_U);
      wait_illum();
      chk("led current", led_cur, exp_cur(lvl, i));
      ser(CH_U_U);
    end
    wr(ADDR_LEDLVL, 32'h0);
    ser(CH_T_U);
    clk(FRAME_CYC);
    chk("led off", led_cur, 7'h00);
    ser(CH_U_U);
    wr(ADDR_LEDLVL, {25'h0, lvl});
    wr(ADDR_CTRL, CTRL_RESET);
    host.set_pins(1'b1, 1'b0, 1'b0);
    clk(8);
    chk("pin trigger", trig, 1'b1);
    host.set_pins(1'b0, 1'b0, 1'b0);
    ser(CH_U_U);
    wr(ADDR_AUTOOFF, 32'd40);
    wr(ADDR_CTRL, CTRL_RESET | 32'h20);
    ser(CH_T_U);
    clk(17);
    chk("auto on", trig, 1'b1);
    clk(30);
    chk("auto off", trig, 1'b0);
    wr(ADDR_AUTOOFF, 32'h0);
    wr(ADDR_CTRL, CTRL_RESET);
    wr(ADDR_EVENT, 32'h1 << EV_BEEP);
    for (k = 0; k < PWM_CYC && snd !== 1'b0; k++)
      clk(1);
    chk("sounder low", snd, 1'b0);
    for (k = 0; k < PWM_CYC && snd !== 1'b1; k++)
      clk(1);
    chk("sounder high", snd, 1'b1);
    wr(ADDR_CTRL, 32'h42);
    clk(12);
    chk("off", off, 1'b1);
    chk("scan power", scan_pwr, 1'b0);
    host.set_pins(1'b0, 1'b1, 1'b0);
    clk(8);
    chk("wake", off, 1'b0);
    clk(20);
    chk("wake held", off, 1'b0);
    host.set_pins(1'b0, 1'b0, 1'b0);
    clk(12);
    chk("off again", off, 1'b1);
    host.set_pins(1'b1, 1'b0, 1'b0);
    clk(10);
    chk("pin wakes", off, 1'b0);
    chk("pin scans", trig, 1'b1);
    wr(ADDR_EVENT, 32'h1 << EV_DECODE);
    clk(3);
    chk("success", good_n, 1'b0);
    wr(ADDR_EVENT, 32'h1 << EV_SENT);
    clk(20);
    chk("held", off, 1'b0);
    host.set_pins(1'b0, 1'b0, 1'b0);
    clk(20);
    chk("released", off, 1'b1);
    host.set_pins(1'b0, 1'b1, 1'b0);
    clk(8);
    wr(ADDR_CTRL, 32'h4a);
    host.set_pins(1'b0, 1'b0, 1'b0);
    clk(20);
    chk("usb no off", off, 1'b0);
    wr(ADDR_CTRL, 32'h44);
    clk(FRAME_CYC);
    chk("pres dark", illum, 1'b0);
    wr(ADDR_EVENT, 32'h1 << EV_CHANGE);
    wait_illum();
    chk("pres lit", illum, 1'b1);
    wr(ADDR_EVENT, 32'h1 << EV_DECODE);
    wr(ADDR_EVENT, 32'h1 << EV_SENT);
    wr(ADDR_CTRL, 32'h46);
    wr(ADDR_EVENT, (32'h1 << EV_CHANGE) | (32'h1 << EV_STANDSYM));
    clk(FRAME_CYC);
    chk("stand dark", illum, 1'b0);
    wr(ADDR_EVENT, 32'h1 << EV_CHANGE);
    wait_illum();
    chk("stand lit", illum, 1'b1);
    apb(1'b1, 8'h3c, 32'h5a5a_5a5a);
    chk("slverr", slv_err, 1'b1);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped read", rd_data, 32'h0);
    wrap_up();
  end
endmodule : tb

bind stic_core stic_monitor mon (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .POLARITY_SELECT_IN(POLARITY_SELECT_IN),
  .TRIGGER_PIN_LOW(TRIGGER_PIN_LOW), .WAKE_REQUEST(WAKE_REQUEST), .RXD_PIN(RXD_PIN),
  .TXD_CORE(TXD_CORE), .TXD_PIN(TXD_PIN), .RXD_CORE(RXD_CORE),
  .TRIGGER_ACTIVE(TRIGGER_ACTIVE), .SCAN_POWER(SCAN_POWER),
  .POWERED_OFF_FLAG(POWERED_OFF_FLAG), .ILLUM_EN(ILLUM_EN), .AIMER_EN(AIMER_EN),
  .EXPOSING(EXPOSING), .LED_CURRENT_LEVEL(LED_CURRENT_LEVEL)
);
